/* File: design/fsv_pkg.sv */
package fsv_pkg;
   localparam int NUM_CH = 18;
   localparam int CLK_MHZ = 250;
   // time figures and the cycle counts derived from them
   localparam int CURRENT_SET_PIN_DGL_NS = 1000;
   localparam int CURRENT_SET_PIN_DGL_CYC = (CURRENT_SET_PIN_DGL_NS * CLK_MHZ + 999) / 1000;
   localparam int LED_DGL_NS = 10000;
   localparam int LED_DGL_CYC = (LED_DGL_NS * CLK_MHZ + 999) / 1000;
   localparam int DELAY_STEP_NS = 1000;
   localparam int DELAY_STEP_CYC = (DELAY_STEP_NS * CLK_MHZ) / 1000;
   localparam int CNT_W = 12;
   // register offsets
   localparam logic [7:0] THERMAL_CTRL_ADDR = 8'h02;
   localparam logic [7:0] FAULT_CONFIG_ADDR = 8'h4d;
   localparam logic [7:0] DET_EN_ADDR = 8'h4c;
   localparam logic [7:0] SHORT_CH_ADDR = 8'h4e;
   localparam logic [7:0] OPEN_CH_ADDR = 8'h51;
   localparam logic [7:0] SLS_CH_ADDR = 8'h54;
   localparam logic [7:0] FAULT_KIND_ADDR = 8'h57;
   localparam logic [7:0] CRC_COUNT_ADDR = 8'h58;
   // reset values
   localparam logic [7:0] THERMAL_CTRL_RST = 8'h00;
   localparam logic [7:0] FAULT_CONFIG_RST = 8'h00;
   localparam logic [7:0] DET_EN_RST = 8'h00;
   localparam logic [7:0] FAULT_KIND_RST = 8'h00;
   // thermal_control fields
   localparam int ROLLOFF_FLOOR_LSB = 0;
   localparam int ROLLOFF_REPORT_BIT = 3;
   localparam int OVERHEAT_REPORT_BIT = 4;
   // fault_config field
   localparam int DELAY_SEL_LSB = 0;
   // fault_kind_flags bits
   localparam int OPEN_BIT = 0;
   localparam int STR_SHORT_BIT = 1;
   localparam int SLS_BIT = 2;
   localparam int CURRENT_SET_PIN_BIT = 3;
   localparam int OVERHEAT_BIT = 4;
   localparam int ROLLOFF_BIT = 5;
   localparam int WDOG_BIT = 6;
   localparam int CRC_BIT = 7;
   // channel fault kinds; detection enables sit at 2*kind and 2*kind+1
   localparam int KIND_OPEN = 0;
   localparam int KIND_SHORT = 1;
   localparam int KIND_SLS = 2;
   localparam int NUM_KIND = 3;

   typedef struct packed {
      logic current_set_pin_overcurrent;
      logic temp_over_shutdown;
      logic temp_below_hyst;
      logic temp_over_rolloff;
      logic supply_undervoltage;
   } fsv_sense_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } fsv_reg_req_t;
endpackage

/* File: design/fsv_fault_supervisor.sv */
// Contract
// - an CURRENT_SET_PIN overcurrent lasting past 1us drops all outputs to 17mA and sets the CURRENT_SET_PIN short flag.
// - after any reported fault flag is set, the fault pin goes low only after the fault delay.
// - when CURRENT_SET_PIN returns to normal, outputs recover and the pin releases after the delay.
// - the eight fault kind flags stay set after the cause and are cleared by writing zero.
// - over-temperature switches all channels off, sets its flag and reports if enabled.
// - channels stay off until below the hysteresis point, then the pin releases after delay.
// - above the roll-off point currents reduce, the flag sets, and reporting is optional.
// - a three-bit field selects the roll-off floor, and roll-off acts only when nonzero.
// - below the roll-off point currents ramp back and the pin releases after the delay.
// - supply undervoltage turns channels off and resets all registers, leaving the pin alone.
// - channel faults detect only with both enables and a PWM pulse over 10us, giving 4mA.
// - a CRC mismatch counts the error, sets the CRC flag and pulls the pin low.
// - a watchdog expiry with a fail-safe strap enters fail-safe and reports loss.
// - detection and actions are the same in fail-safe as in normal state.
// - the fault pin is open drain, driven low while reporting, released after delay.
// - per-channel flags clear themselves in the first PWM on phase after that channel's condition ends.
`timescale 1ns/1ps
`default_nettype none
module fsv_fault_supervisor #(
   parameter int N_CH = fsv_pkg::NUM_CH
) (
   input wire logic clock, // core clock
   input wire logic rst_n, // sync reset, active low
   input wire fsv_pkg::fsv_sense_t sense, // analog comparator levels
   input wire logic [N_CH-1:0] ch_open, // per-channel open comparator
   input wire logic [N_CH-1:0] ch_short, // per-channel string short comparator
   input wire logic [N_CH-1:0] ch_sls, // per-channel single short comparator
   input wire logic [N_CH-1:0] pwm_on, // per-channel PWM on phase
   input wire logic failsafe_strap_sel, // strap selects a fail-safe mode
   input wire logic crc_mismatch, // one-cycle pulse from frame logic
   input wire logic watchdog_expired, // one-cycle pulse from watchdog
   input wire fsv_pkg::fsv_reg_req_t reg_req, // register request
   output logic [7:0] reg_rdata, // read data, one cycle after rd
   output logic fault_out_n_o, // pin level when driven, always low
   output logic fault_out_n_oe, // pin enable, high pulls low
   output logic all_off, // all channels forced off
   output logic reduce_17ma, // all channels at 17mA
   output logic rolloff_active, // linear current roll-off engaged
   output logic [2:0] rolloff_floor_sel, // roll-off floor to the current DAC
   output logic [N_CH-1:0] ch_retry_4ma, // channel held at 4mA retry
   output logic failsafe_mode, // fail-safe operation
   output logic [7:0] crc_err_count // saturating CRC error count
);
   import fsv_pkg::*;

   fsv_sense_t sense_m;
   fsv_sense_t sense_s;
   logic [N_CH-1:0] open_m, open_s;
   logic [N_CH-1:0] short_m, short_s;
   logic [N_CH-1:0] sls_m, sls_s;
   logic [N_CH-1:0] pwm_m, pwm_s;
   logic strap_m, strap_s;
   logic clr;
   logic [7:0] thermal_ctrl_reg;
   logic [7:0] fault_config_reg;
   logic [7:0] det_en_reg;
   logic [7:0] fault_kind_flags;
   logic [7:0] next_flags;
   logic [7:0] flag_set;
   logic [CNT_W-1:0] current_set_pin_cnt;
   logic current_set_pin_active;
   logic overheat_hold;
   logic strap_seen;
   logic strap_cap;
   logic report_want;
   logic [CNT_W-1:0] pin_cnt;
   logic [CNT_W-1:0] delay_cyc;
   logic [N_CH-1:0] kind_any;
   wire [NUM_KIND-1:0][N_CH-1:0] ch_flag;
   wire [NUM_KIND-1:0][N_CH-1:0] ch_raw;
   wire [NUM_KIND-1:0] kind_set;
   logic [NUM_KIND-1:0][23:0] ch_flag_rd;
   logic rolloff_on;
   logic wr_flags;
   logic [7:0] crc_limit;

   // comparators are asynchronous to the core clock
   always_ff @(posedge clock) begin
      sense_m <= sense;
      sense_s <= sense_m;
      open_m <= ch_open;
      open_s <= open_m;
      short_m <= ch_short;
      short_s <= short_m;
      sls_m <= ch_sls;
      sls_s <= sls_m;
      pwm_m <= pwm_on;
      pwm_s <= pwm_m;
      strap_m <= failsafe_strap_sel;
      strap_s <= strap_m;
   end

   // undervoltage acts as a register reset but never touches the pin
   assign clr = !rst_n || sense_s.supply_undervoltage;

   assign ch_raw[KIND_OPEN] = open_s;
   assign ch_raw[KIND_SHORT] = short_s;
   assign ch_raw[KIND_SLS] = sls_s;
   assign wr_flags = reg_req.wr && reg_req.addr == FAULT_KIND_ADDR;
   assign crc_limit = 8'hff;

   // register writes
   always_ff @(posedge clock) begin
      if (clr) begin
         thermal_ctrl_reg <= THERMAL_CTRL_RST;
         fault_config_reg <= FAULT_CONFIG_RST;
         det_en_reg <= DET_EN_RST;
      end else if (reg_req.wr) begin
         case (reg_req.addr)
            THERMAL_CTRL_ADDR: thermal_ctrl_reg <= reg_req.wdata;
            FAULT_CONFIG_ADDR: fault_config_reg <= reg_req.wdata;
            DET_EN_ADDR: det_en_reg <= reg_req.wdata;
            default: begin
            end
         endcase
      end
   end

   // per-channel deglitch; counting only in the PWM on phase
   genvar k, c;
   generate
      for (k = 0; k < NUM_KIND; k++) begin : g_kind
         for (c = 0; c < N_CH; c++) begin : g_ch
            logic [CNT_W-1:0] cnt;
            logic flag;
            logic armed;
            assign armed = det_en_reg[2*k] && det_en_reg[2*k+1];
            always_ff @(posedge clock) begin
               if (clr || !armed) begin
                  cnt <= '0;
                  flag <= 1'b0;
               end else if (pwm_s[c]) begin
                  if (!ch_raw[k][c]) begin
                     cnt <= '0;
                     flag <= 1'b0;
                  end else if (cnt >= CNT_W'(LED_DGL_CYC)) begin
                     flag <= 1'b1;
                  end else begin
                     cnt <= cnt + 1'b1;
                  end
               end else begin
                  cnt <= '0; // short pulses never reach the deglitch
               end
            end
            assign ch_flag[k][c] = flag;
         end
         assign kind_set[k] = |ch_flag[k];
      end
   endgenerate

   always_comb begin
      for (int i = 0; i < N_CH; i++) begin
         kind_any[i] = ch_flag[KIND_OPEN][i] || ch_flag[KIND_SHORT][i] || ch_flag[KIND_SLS][i];
      end
   end

   // faulty channels keep a retry current, the rest stay on
   always_ff @(posedge clock) begin
      if (clr) begin
         ch_retry_4ma <= '0;
      end else begin
         ch_retry_4ma <= kind_any;
      end
   end

   // current-set pin short
   // counter parks at the limit so a lasting short never wraps and re-arms
   always_ff @(posedge clock) begin
      if (clr) begin
         current_set_pin_cnt <= '0;
         current_set_pin_active <= 1'b0;
      end else if (!sense_s.current_set_pin_overcurrent) begin
         current_set_pin_cnt <= '0;
         current_set_pin_active <= 1'b0;
      end else if (current_set_pin_cnt >= CNT_W'(CURRENT_SET_PIN_DGL_CYC)) begin
         current_set_pin_active <= 1'b1;
      end else begin
         current_set_pin_cnt <= current_set_pin_cnt + 1'b1;
      end
   end

   // thermal shutdown; restart blocked until below hysteresis
   always_ff @(posedge clock) begin
      if (clr) begin
         overheat_hold <= 1'b0;
      end else if (sense_s.temp_over_shutdown) begin
         overheat_hold <= 1'b1;
      end else if (sense_s.temp_below_hyst) begin
         overheat_hold <= 1'b0;
      end
   end

   // field read from the register so a zero write stops roll-off in the same cycle
   assign rolloff_on = sense_s.temp_over_rolloff && thermal_ctrl_reg[ROLLOFF_FLOOR_LSB +: 3] != 3'b000;

   // strap captured once after reset release
   // a strap change later on is ignored until the next reset or undervoltage
   always_ff @(posedge clock) begin
      if (clr) begin
         strap_seen <= 1'b0;
         strap_cap <= 1'b0;
      end else if (!strap_seen) begin
         strap_seen <= 1'b1;
         strap_cap <= strap_s;
      end
   end

   // hardware set events gathered in one vector
   always_comb begin
      flag_set = 8'h00;
      flag_set[OPEN_BIT] = kind_set[KIND_OPEN];
      flag_set[STR_SHORT_BIT] = kind_set[KIND_SHORT];
      flag_set[SLS_BIT] = kind_set[KIND_SLS];
      flag_set[CURRENT_SET_PIN_BIT] = current_set_pin_active;
      flag_set[OVERHEAT_BIT] = overheat_hold;
      flag_set[ROLLOFF_BIT] = rolloff_on;
      flag_set[WDOG_BIT] = watchdog_expired && strap_cap;
      flag_set[CRC_BIT] = crc_mismatch;
   end

   // latched kind flags: a set in the same cycle as a host clear wins
   always_comb begin
      next_flags = fault_kind_flags;
      if (wr_flags) begin
         next_flags = fault_kind_flags & reg_req.wdata;
      end
      next_flags = next_flags | flag_set;
   end

   always_ff @(posedge clock) begin
      if (clr) begin
         fault_kind_flags <= FAULT_KIND_RST;
      end else begin
         fault_kind_flags <= next_flags;
      end
   end

   // fail-safe leaves when the host acknowledges the loss
   always_ff @(posedge clock) begin
      if (clr) begin
         failsafe_mode <= 1'b0;
      end else if (watchdog_expired && strap_cap) begin
         failsafe_mode <= 1'b1;
      end else if (!fault_kind_flags[WDOG_BIT]) begin
         failsafe_mode <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (clr) begin
         crc_err_count <= 8'h00;
      end else if (crc_mismatch && crc_err_count != crc_limit) begin
         // saturating, so a burst of errors never wraps back to a small count
         crc_err_count <= crc_err_count + 8'h01;
      end
   end

   // channel actions, identical in fail-safe and normal state
   always_ff @(posedge clock) begin
      if (clr) begin
         all_off <= 1'b1;
         reduce_17ma <= 1'b0;
         rolloff_active <= 1'b0;
         rolloff_floor_sel <= 3'b000;
      end else begin
         all_off <= overheat_hold;
         reduce_17ma <= current_set_pin_active;
         rolloff_active <= rolloff_on;
         rolloff_floor_sel <= thermal_ctrl_reg[ROLLOFF_FLOOR_LSB +: 3];
      end
   end

   // live causes release the pin on their own; crc and watchdog wait for the host
   always_comb begin
      report_want = |kind_any || current_set_pin_active;
      if (overheat_hold && thermal_ctrl_reg[OVERHEAT_REPORT_BIT]) begin
         report_want = 1'b1;
      end
      if (rolloff_on && thermal_ctrl_reg[ROLLOFF_REPORT_BIT]) begin
         report_want = 1'b1;
      end
      if (fault_kind_flags[CRC_BIT] || fault_kind_flags[WDOG_BIT]) begin
         report_want = 1'b1;
      end
   end

   // a report level shorter than the delay never reaches the pin
   assign delay_cyc = CNT_W'(fault_config_reg[DELAY_SEL_LSB +: 4]) * CNT_W'(DELAY_STEP_CYC);

   // pin follows the report level, each change held back by the delay
   // undervoltage leaves this alone; only rst_n clears the pin state
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pin_cnt <= '0;
         fault_out_n_oe <= 1'b0;
      end else if (report_want == fault_out_n_oe) begin
         pin_cnt <= '0;
      end else if (pin_cnt >= delay_cyc) begin
         pin_cnt <= '0;
         fault_out_n_oe <= report_want;
      end else begin
         pin_cnt <= pin_cnt + 1'b1;
      end
   end

   // open drain: only ever drives low
   always_ff @(posedge clock) begin
      fault_out_n_o <= 1'b0;
   end

   // channel flags padded to three bytes per kind for the read window
   always_comb begin
      for (int i = 0; i < NUM_KIND; i++) begin
         ch_flag_rd[i] = 24'(ch_flag[i]);
      end
   end

   always_ff @(posedge clock) begin
      if (clr) begin
         reg_rdata <= 8'h00;
      end else if (reg_req.rd) begin
         case (reg_req.addr)
            THERMAL_CTRL_ADDR: reg_rdata <= thermal_ctrl_reg;
            FAULT_CONFIG_ADDR: reg_rdata <= fault_config_reg;
            DET_EN_ADDR: reg_rdata <= det_en_reg;
            SHORT_CH_ADDR: reg_rdata <= ch_flag_rd[KIND_SHORT][7:0];
            SHORT_CH_ADDR + 8'h01: reg_rdata <= ch_flag_rd[KIND_SHORT][15:8];
            SHORT_CH_ADDR + 8'h02: reg_rdata <= ch_flag_rd[KIND_SHORT][23:16];
            OPEN_CH_ADDR: reg_rdata <= ch_flag_rd[KIND_OPEN][7:0];
            OPEN_CH_ADDR + 8'h01: reg_rdata <= ch_flag_rd[KIND_OPEN][15:8];
            OPEN_CH_ADDR + 8'h02: reg_rdata <= ch_flag_rd[KIND_OPEN][23:16];
            SLS_CH_ADDR: reg_rdata <= ch_flag_rd[KIND_SLS][7:0];
            SLS_CH_ADDR + 8'h01: reg_rdata <= ch_flag_rd[KIND_SLS][15:8];
            SLS_CH_ADDR + 8'h02: reg_rdata <= ch_flag_rd[KIND_SLS][23:16];
            FAULT_KIND_ADDR: reg_rdata <= fault_kind_flags;
            CRC_COUNT_ADDR: reg_rdata <= crc_err_count;
            default: reg_rdata <= 8'h00;
         endcase
      end
   end
endmodule
`default_nettype wire

/* File: bench/fsv_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fsv_host_model (
   input wire logic fault_out_n_o, // pin level when driven
   input wire logic fault_out_n_oe, // pin enable
   output logic fault_pin // line seen by the host
);
   // the host pull-up wins whenever the device lets go of the line
   assign fault_pin = fault_out_n_oe ? fault_out_n_o : 1'b1;
endmodule
`default_nettype wire

/* File: bench/fsv_fault_supervisor_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module fsv_fault_supervisor_monitor #(
   parameter int N_CH = 18
) (
   input wire logic clock, // clk
   input wire logic rst_n, // reset
   input wire fsv_pkg::fsv_sense_t sense, // levels
   input wire logic [N_CH-1:0] ch_open, // open
   input wire logic [N_CH-1:0] ch_short, // short
   input wire logic [N_CH-1:0] ch_sls, // single short
   input wire logic [N_CH-1:0] pwm_on, // pwm
   input wire logic failsafe_strap_sel, // strap
   input wire logic crc_mismatch, // crc pulse
   input wire logic watchdog_expired, // wdog pulse
   input wire fsv_pkg::fsv_reg_req_t reg_req, // register request
   input wire logic fault_out_n_o, // pin level
   input wire logic fault_out_n_oe, // pin enable
   input wire logic all_off, // off
   input wire logic reduce_17ma, // 17ma
   input wire logic rolloff_active, // roll-off
   input wire logic [2:0] rolloff_floor_sel, // floor
   input wire logic [N_CH-1:0] ch_retry_4ma, // retry
   input wire logic failsafe_mode, // fail-safe
   input wire logic [7:0] crc_err_count // count
);
   import fsv_pkg::*;
   logic [3:0] uv_h;
   // undervoltage clears registers through a synchroniser, so mask its tail too
   always_ff @(posedge clock) uv_h <= rst_n ? {uv_h[2:0], sense.supply_undervoltage} : 4'h0;
   // longest delay plus a little slack; too long for a delay range, so counted here
   localparam logic [12:0] CRC_PIN_LIMIT = 13'h0eb0;
   logic crc_wait;
   logic crc_clr;
   logic [12:0] crc_wait_cnt;
   assign crc_clr = reg_req.wr && reg_req.addr == FAULT_KIND_ADDR && !reg_req.wdata[CRC_BIT];
   always_ff @(posedge clock) begin
      if (!rst_n || sense.supply_undervoltage || fault_out_n_oe) begin
         crc_wait <= 1'b0;
         crc_wait_cnt <= 13'h0000;
      end else if (crc_mismatch || (crc_wait && !crc_clr)) begin
         crc_wait <= 1'b1;
         crc_wait_cnt <= crc_wait_cnt + 13'h0001;
      end else begin
         crc_wait <= 1'b0;
         crc_wait_cnt <= 13'h0000;
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n || sense.supply_undervoltage || uv_h != 4'h0);
   sequence s_hot;
      sense.temp_over_shutdown [*4];
   endsequence
   a_pin_drive_low: assert property (fault_out_n_oe |-> !fault_out_n_o)
      else $error("fault pin driven high");
   a_crc_count_up: assert property (crc_mismatch && crc_err_count != 8'hff |=>
      crc_err_count == $past(crc_err_count) + 8'h01) else $error("crc count not advanced");
   a_crc_pin_low: assert property (crc_wait_cnt <= CRC_PIN_LIMIT)
      else $error("crc not reported on pin");
   a_current_set_pin_deglitch: assert property ($rose(reduce_17ma) |->
      $past(sense.current_set_pin_overcurrent, 4) && $past(sense.current_set_pin_overcurrent, 200))
      else $error("17ma reduction without long overcurrent");
   a_hot_all_off: assert property (s_hot |-> ##[0:3] all_off)
      else $error("channels not off when hot");
   a_no_hot_restart: assert property ($fell(all_off) |-> $past(sense.temp_below_hyst, 2))
      else $error("restart before cooling");
   a_floor_nonzero: assert property (rolloff_active |-> rolloff_floor_sel != 3'h0)
      else $error("roll-off with zero floor");
   a_retry_cause: assert property ($rose(|ch_retry_4ma) |->
      $past(|pwm_on, 4) && $past(|(ch_open | ch_short | ch_sls), 4))
      else $error("retry without channel fault");
   a_wdog_failsafe: assert property (watchdog_expired && failsafe_strap_sel |->
      ##[1:3] failsafe_mode) else $error("fail-safe not entered");
endmodule
bind fsv_fault_supervisor fsv_fault_supervisor_monitor #(.N_CH(N_CH)) u_mon (
   .clock(clock), .rst_n(rst_n), .sense(sense), .ch_open(ch_open), .ch_short(ch_short),
   .ch_sls(ch_sls), .pwm_on(pwm_on), .failsafe_strap_sel(failsafe_strap_sel),
   .crc_mismatch(crc_mismatch), .watchdog_expired(watchdog_expired), .reg_req(reg_req),
   .fault_out_n_o(fault_out_n_o), .fault_out_n_oe(fault_out_n_oe), .all_off(all_off),
   .reduce_17ma(reduce_17ma), .rolloff_active(rolloff_active),
   .rolloff_floor_sel(rolloff_floor_sel), .ch_retry_4ma(ch_retry_4ma),
   .failsafe_mode(failsafe_mode), .crc_err_count(crc_err_count));
`default_nettype wire

/* File: bench/fsv_fault_supervisor_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module fsv_fault_supervisor_tb;
   import fsv_pkg::*;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   fsv_sense_t sense = 5'b00100;
   logic [NUM_CH-1:0] chf[3] = '{default: '0};
   logic [NUM_CH-1:0] pwm_on = '0;
   logic crc_p = 1'b0;
   logic wd_p = 1'b0;
   logic strap = 1'b1;
   logic [7:0] ccount;
   fsv_reg_req_t req = '0;
   logic [7:0] rdata;
   logic oe, o_lvl, all_off, red, roll, fs, fault_pin, rd_d, rd_d2;
   logic [2:0] floor;
   logic [NUM_CH-1:0] retry, mask;
   logic [3:0] ft;
   logic [7:0] expq[$];
   logic [7:0] base[3] = '{OPEN_CH_ADDR, SHORT_CH_ADDR, SLS_CH_ADDR};
   logic [7:0] addrs[6] = '{8'h02, 8'h4c, 8'h4d, 8'h57, 8'h58, 8'hff};
   int n_fail = 0;
   int total_checks = 0;
   int seed = 85735;
   int cyc = 0;
   int ch;
   fsv_fault_supervisor dut (.clock(clock), .rst_n(rst_n), .sense(sense), .ch_open(chf[0]),
      .ch_short(chf[1]), .ch_sls(chf[2]), .pwm_on(pwm_on), .failsafe_strap_sel(strap),
      .crc_mismatch(crc_p), .watchdog_expired(wd_p), .reg_req(req), .reg_rdata(rdata),
      .fault_out_n_o(o_lvl), .fault_out_n_oe(oe), .all_off(all_off), .reduce_17ma(red),
      .rolloff_active(roll), .rolloff_floor_sel(floor), .ch_retry_4ma(retry),
      .failsafe_mode(fs), .crc_err_count(ccount));
   fsv_host_model host (.fault_out_n_o(o_lvl), .fault_out_n_oe(oe), .fault_pin(fault_pin));
   initial forever #2 clock = ~clock;
   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cyc_n(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      req.wr = 1'b1;
      req.addr = a;
      req.wdata = d;
      cyc_n(1);
      req.wr = 1'b0;
      cyc_n(1);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      req.rd = 1'b1;
      req.addr = a;
      expq.push_back(e);
      cyc_n(1);
      req.rd = 1'b0;
      cyc_n(2);
   endtask
   // read data lands one edge after the strobe edge; judged at the falling edge
   always @(posedge clock) begin
      rd_d <= req.rd;
      rd_d2 <= rd_d;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         test_done();
      end
   end
   always @(negedge clock) begin
      if (rd_d2 && expq.size() > 0)
         chk("read data", expq.pop_front(), rdata);
   end
   initial begin
      cyc_n(8);
      rst_n = 1'b1;
      cyc_n(4);
      foreach (addrs[i]) rd(addrs[i], 8'h00);
      $display("test reset values done");
      for (int k = 0; k < 2; k++) begin
         ft = (k == 0) ? 4'h0 : 4'(1 + $unsigned($random(seed)) % 3);
         wr(FAULT_CONFIG_ADDR, {4'h0, ft});
         crc_p = 1'b1;
         cyc_n(1);
         crc_p = 1'b0;
         if (ft != 0) begin
            cyc_n(ft * 250 - 4);
            chk("pin before delay", 1, fault_pin);
         end
         cyc_n(ft == 0 ? 2 : 7);
         chk("pin crc", 0, fault_pin);
         rd(FAULT_KIND_ADDR, 8'h80);
         rd(CRC_COUNT_ADDR, 8'(k + 1));
         chk("crc count port", k + 1, ccount);
         wr(FAULT_KIND_ADDR, 8'h7f);
         rd(FAULT_KIND_ADDR, 8'h00);
         cyc_n(ft * 250 + 4);
         chk("pin crc cleared", 1, fault_pin);
      end
      $display("test crc done");
      wr(FAULT_CONFIG_ADDR, 8'h00);
      sense.current_set_pin_overcurrent = 1'b1;
      cyc_n(200);
      chk("reduce early", 0, red);
      cyc_n(60);
      chk("reduce", 1, red);
      chk("pin current_set_pin", 0, fault_pin);
      sense.current_set_pin_overcurrent = 1'b0;
      cyc_n(8);
      chk("reduce end", 0, red);
      chk("pin current_set_pin end", 1, fault_pin);
      rd(FAULT_KIND_ADDR, 8'h08);
      wr(FAULT_KIND_ADDR, 8'h00);
      $display("test current_set_pin done");
      wr(THERMAL_CTRL_ADDR, 8'h10);
      sense.temp_below_hyst = 1'b0;
      sense.temp_over_shutdown = 1'b1;
      cyc_n(8);
      chk("off hot", 1, all_off);
      chk("pin hot", 0, fault_pin);
      sense.temp_over_shutdown = 1'b0;
      cyc_n(8);
      chk("off cooling", 1, all_off);
      sense.temp_below_hyst = 1'b1;
      cyc_n(8);
      chk("off cool", 0, all_off);
      chk("pin cool", 1, fault_pin);
      rd(FAULT_KIND_ADDR, 8'h10);
      wr(FAULT_KIND_ADDR, 8'h00);
      $display("test shutdown done");
      for (int k = 0; k < 3; k++) begin
         wr(THERMAL_CTRL_ADDR, k == 0 ? 8'h08 : (k == 1 ? 8'h05 : 8'h0d));
         sense.temp_over_rolloff = 1'b1;
         cyc_n(8);
         chk("rolloff", k != 0, roll);
         chk("floor", k ? 5 : 0, floor);
         chk("pin rolloff", k != 2, fault_pin);
         sense.temp_over_rolloff = 1'b0;
         cyc_n(8);
         chk("rolloff end", 0, roll);
         chk("pin rolloff end", 1, fault_pin);
         rd(FAULT_KIND_ADDR, k ? 8'h20 : 8'h00);
      end
      wr(FAULT_KIND_ADDR, 8'h00);
      $display("test rolloff done");
      pwm_on = '1;
      for (int k = 0; k < NUM_KIND; k++) begin
         ch = $unsigned($random(seed)) % NUM_CH;
         mask = '0;
         mask[ch] = 1'b1;
         wr(DET_EN_ADDR, 8'(3 << (2 * k)));
         chf[k] = mask;
         cyc_n(2400);
         chk("retry early", 0, retry);
         cyc_n(120);
         chk("retry", mask, retry);
         chk("pin channel", 0, fault_pin);
         rd(base[k] + 8'(ch / 8), 8'(1 << (ch % 8)));
         chf[k] = '0;
         cyc_n(8);
         chk("retry end", 0, retry);
         rd(base[k] + 8'(ch / 8), 8'h00);
         rd(FAULT_KIND_ADDR, 8'(1 << k));
         wr(FAULT_KIND_ADDR, 8'h00);
      end
      $display("test channel done");
      wd_p = 1'b1;
      cyc_n(1);
      wd_p = 1'b0;
      cyc_n(3);
      chk("failsafe", 1, fs);
      chk("pin wdog", 0, fault_pin);
      rd(FAULT_KIND_ADDR, 8'h40);
      wr(FAULT_KIND_ADDR, 8'h00);
      cyc_n(4);
      chk("failsafe end", 0, fs);
      chk("pin wdog end", 1, fault_pin);
      $display("test watchdog done");
      wr(THERMAL_CTRL_ADDR, 8'h1b);
      strap = 1'b0;
      sense.supply_undervoltage = 1'b1;
      cyc_n(6);
      chk("off uvlo", 1, all_off);
      sense.supply_undervoltage = 1'b0;
      cyc_n(6);
      rd(THERMAL_CTRL_ADDR, 8'h00);
      rd(CRC_COUNT_ADDR, 8'h00);
      chk("crc count port uvlo", 0, ccount);
      wd_p = 1'b1;
      cyc_n(1);
      wd_p = 1'b0;
      cyc_n(3);
      chk("failsafe no strap", 0, fs);
      rd(FAULT_KIND_ADDR, 8'h00);
      $display("test uvlo done");
      test_done();
   end
endmodule
`default_nettype wire
